// File: dmahs_regs.svh
/*
  Constants for the DMA channel handshake block: channel count, pin polarity,
  transfer phase timing and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef DMAHS_REGS_SVH
`define DMAHS_REGS_SVH

`define DMAHS_NCH 4
`define DMAHS_CLK_MHZ 10
`define DMAHS_ACCESS_NS 100
`define DMAHS_ACCESS_CYC ((`DMAHS_ACCESS_NS * `DMAHS_CLK_MHZ + 999) / 1000)
`define DMAHS_CNT_W 16
`define DMAHS_ACK_IDLE 4'hf
`define DMAHS_PIN_OE_OFF 4'hf
`define DMAHS_PIN_IDLE 4'hf
`define DMAHS_REQ_SETTLE 2'h2
`define DMAHS_PRIO_FIXED 1'h0
`define DMAHS_PRIO_ROTATE 1'h1
`define DMAHS_PIN_AS_INPUT 1'h0
`define DMAHS_PIN_AS_OUTPUT 1'h1

`endif

// File: dmahs_pkg.sv
/*
  Types of the DMA channel handshake block.
  Assumes dmahs_regs.svh is in the include path.
*/
`include "dmahs_regs.svh"

package dmahs_pkg;

  typedef enum logic [3:0] {
    DMAHS_IDLE = 4'h1,
    DMAHS_REQ_ACC = 4'h2,
    DMAHS_MEM_ACC = 4'h4,
    DMAHS_DONE = 4'h8
  } dmahs_state_t;

  // Per-channel programming from the channel setup logic
  typedef struct packed {
    logic pin_is_output;
    logic src_dst_chain;
    logic [`DMAHS_CNT_W-1:0] byte_count;
    logic [1:0] accesses_per_req;
    logic req_first;
  } dmahs_chan_cfg_t;

  // Status of the channel in service
  typedef struct packed {
    logic busy;
    logic [1:0] chan;
    logic [`DMAHS_CNT_W-1:0] remaining;
  } dmahs_status_t;

endpackage

// File: dmahs_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous inputs.
  Assumes the inputs are levels held for at least two clock periods.
*/
`timescale 1ns/100ps

module dmahs_sync
  import dmahs_pkg::*;
#(
  parameter int W = 4
)
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic [W-1:0] i_async, // Raw asynchronous input
  input wire logic [W-1:0] i_idle, // Level to take in reset
  output logic [W-1:0] o_sync // Synchronised level
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_q <= i_idle;
      o_sync <= i_idle;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// File: dmahs_arb.sv
/*
  Priority arbiter for the four channel requests: fixed (channel 0 highest)
  or rotating (last served drops to lowest).
  Assumes requests are synchronous and one grant is taken per cycle.
*/
`timescale 1ns/100ps
`include "dmahs_regs.svh"

module dmahs_arb
  import dmahs_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_mode, // Priority mode select
  input wire logic [3:0] i_req, // Pending requests, active high
  input wire logic i_take, // Grant accepted this cycle
  output logic o_valid, // A request is pending
  output logic [1:0] o_chan // Winning channel
);

  logic [1:0] last_q;
  logic [1:0] start;

  function automatic logic [1:0] pick(input logic [3:0] req, input logic [1:0] first);
    logic [1:0] c;
    logic [1:0] r;
    r = first;
    for (int i = 3; i >= 0; i--)
    begin
      c = 2'(first + 2'(i));
      if (req[c])
        r = c;
    end
    return r;
  endfunction

  always_comb
  begin
    start = (i_mode == `DMAHS_PRIO_ROTATE) ? 2'(last_q + 2'h1) : 2'h0; // R3
    o_valid = |i_req;
    o_chan = pick(i_req, start); // R2
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      last_q <= 2'h3;
    else if (i_take)
      last_q <= o_chan;
  end

endmodule

// File: dmahs_top.sv
/*
  DMA channel handshake: four request inputs, four acknowledge outputs and four
  shared end-of-process / count-done pins, with a programmable priority scheme.
  Assumes the transfer engine moves the data and the pins are active low.
  Assumes the channel setup logic holds i_cfg steady while a channel runs.
*/
//
// Function
// R1: Each request line asks for a transfer on its own channel only.
// R2: Among simultaneous requests the highest-priority channel is served first.
// R3: Arbitration follows the software-selected priority scheme.
// R4: Each acknowledge line marks a transfer running on its channel.
// R5: Acknowledge is asserted only during the access to the requesting device.
// R6: Each end/count pin is set on its own as input or output, never both.
// R7: An asserted end input terminates the matching channel's transfer.
// R8: With source and destination chaining, end input ends only this buffer.
// R9: End inputs are synchronised before use.
// R10: Configured as output, the pin shows count reached zero and buffer done.
// R11: Count-done output has exactly the acknowledge line's timing.
// R12: Count-done stays asserted across all accesses of the last request.
// R13: A requester holds its line until acknowledged and drops it when done.
`timescale 1ns/100ps
`include "dmahs_regs.svh"

module dmahs_top
  import dmahs_pkg::*;
(
  input wire logic i_clk, // Clock, 10 MHz
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic [3:0] i_channel_transfer_request_n, // Requests, active low
  output logic [3:0] o_channel_transfer_ack_n, // Acknowledges, active low
  input wire logic [3:0] i_channel_end_or_count_pin, // Pin level in
  output logic [3:0] o_channel_end_or_count_pin, // Pin level out
  output logic [3:0] o_channel_end_or_count_pin_oe_n, // Pin drive, low drives
  input wire logic i_prio_mode, // Priority scheme select
  input wire dmahs_chan_cfg_t [3:0] i_cfg, // Per-channel programming
  input wire logic [3:0] i_chan_enable, // Channel enables
  output logic [3:0] o_buffer_done, // Buffer finished, pulse
  output logic [3:0] o_chan_terminated, // Channel ended by input, pulse
  output dmahs_status_t o_status // Status of the channel in service
);

  logic [3:0] req_sync;
  logic [3:0] end_sync;
  logic [3:0] end_input;
  logic [3:0] req_act;
  logic arb_valid;
  logic [1:0] arb_chan;
  logic take;
  logic buf_last;
  logic end_hit;
  logic [1:0] ack_chan;
  logic ack_last;
  logic [3:0] pin_out_en;

  dmahs_state_t state_q;
  dmahs_state_t state_d;
  logic [1:0] chan_q;
  logic [1:0] acc_q;
  logic [`DMAHS_CNT_W-1:0] cnt_q [4];
  logic [3:0] loaded_q;
  logic last_req_q;
  logic end_q;
  logic [1:0] settle_q;

  // Requests cross into the clock domain like any other pin
  dmahs_sync #(.W(4)) u_req_sync
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_channel_transfer_request_n),
    .i_idle(`DMAHS_PIN_IDLE),
    .o_sync(req_sync)
  );

  dmahs_sync #(.W(4)) u_end_sync // R9
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_channel_end_or_count_pin),
    .i_idle(`DMAHS_PIN_IDLE),
    .o_sync(end_sync)
  );

  function automatic logic [3:0] onehot(input logic [1:0] c);
    return 4'(4'h1 << c);
  endfunction

  // Last request of a buffer: a fresh buffer of one, or a running count at one
  function automatic logic last_of(input logic loaded, input logic [`DMAHS_CNT_W-1:0] cnt,
    input logic [`DMAHS_CNT_W-1:0] fresh);
    return loaded ? (cnt == `DMAHS_CNT_W'(1)) : (fresh == `DMAHS_CNT_W'(1));
  endfunction

  // Requests and end inputs as seen after the synchronisers
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      end_input[i] = !end_sync[i] && (i_cfg[i].pin_is_output == `DMAHS_PIN_AS_INPUT); // R6
    req_act = ~req_sync & i_chan_enable; // R1
    take = (state_q == DMAHS_IDLE) && arb_valid && (settle_q == 2'h0);
    end_hit = end_input[chan_q] && (state_q != DMAHS_IDLE); // R7
    buf_last = (cnt_q[chan_q] == `DMAHS_CNT_W'(1));
  end

  // Channel and last-transfer flag of the requester access about to start
  always_comb
  begin
    ack_chan = take ? arb_chan : chan_q;
    ack_last = take ? last_of(loaded_q[arb_chan], cnt_q[arb_chan], i_cfg[arb_chan].byte_count)
      : last_req_q;
    for (int i = 0; i < 4; i++)
      pin_out_en[i] = (i_cfg[i].pin_is_output == `DMAHS_PIN_AS_OUTPUT); // R6
  end

  // Arbiter sees only enabled requests and has a grant taken only when idle
  dmahs_arb u_arb
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_mode(i_prio_mode),
    .i_req(req_act),
    .i_take(take),
    .o_valid(arb_valid),
    .o_chan(arb_chan)
  );

  // One request: access to requester and access to memory, order per config
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DMAHS_IDLE:
        if (take)
          state_d = i_cfg[arb_chan].req_first ? DMAHS_REQ_ACC : DMAHS_MEM_ACC;
      DMAHS_REQ_ACC:
        if (acc_q == 2'h0)
          state_d = i_cfg[chan_q].req_first ? DMAHS_MEM_ACC : DMAHS_DONE;
      DMAHS_MEM_ACC:
        state_d = i_cfg[chan_q].req_first ? DMAHS_DONE : DMAHS_REQ_ACC;
      DMAHS_DONE:
        state_d = DMAHS_IDLE;
      default:
        state_d = DMAHS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      state_q <= DMAHS_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      chan_q <= 2'h0;
    else if (take)
      chan_q <= arb_chan; // R2
  end

  // No new grant until the served requester's release has crossed the synchroniser
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      settle_q <= 2'h0;
    else if (state_q == DMAHS_REQ_ACC)
      settle_q <= `DMAHS_REQ_SETTLE;
    else if (settle_q != 2'h0)
      settle_q <= 2'(settle_q - 2'h1);
  end

  // Access counter for a request split into several bus accesses
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      acc_q <= 2'h0;
    else if (take)
      acc_q <= i_cfg[arb_chan].accesses_per_req;
    else if (state_q == DMAHS_REQ_ACC && acc_q != 2'h0)
      acc_q <= 2'(acc_q - 2'h1);
  end

  // End input latched for the request in flight
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      end_q <= 1'h0;
    else if (take)
      end_q <= 1'h0;
    else if (end_hit)
      end_q <= 1'h1; // R7
  end

  // Last-request flag kept for the requester accesses that follow the grant cycle, whichever access opens the request
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      last_req_q <= 1'h0;
    else if (take)
      last_req_q <= ack_last; // R12
  end

  // Byte counts per channel, reloaded when the next buffer starts
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < 4; i++)
        cnt_q[i] <= '0;
      loaded_q <= 4'h0;
    end
    else
    begin
      if (take && !loaded_q[arb_chan])
      begin
        cnt_q[arb_chan] <= i_cfg[arb_chan].byte_count;
        loaded_q[arb_chan] <= 1'h1;
      end
      if (state_q == DMAHS_DONE)
      begin
        if (buf_last || end_q)
        begin
          cnt_q[chan_q] <= '0;
          loaded_q[chan_q] <= 1'h0; // R8
        end
        else
          cnt_q[chan_q] <= `DMAHS_CNT_W'(cnt_q[chan_q] - `DMAHS_CNT_W'(1));
      end
    end
  end

  // Acknowledge marks the whole requester access phase
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_channel_transfer_ack_n <= `DMAHS_ACK_IDLE;
    else if (state_d == DMAHS_REQ_ACC)
      o_channel_transfer_ack_n <= ~onehot(ack_chan); // R4 R5
    else
      o_channel_transfer_ack_n <= `DMAHS_ACK_IDLE; // R5
  end

  // Count-done copies the acknowledge during the last request, output pins only
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_channel_end_or_count_pin <= `DMAHS_PIN_IDLE;
    else if (state_d == DMAHS_REQ_ACC && ack_last)
      o_channel_end_or_count_pin <= ~(onehot(ack_chan) & pin_out_en); // R10 R11 R12
    else
      o_channel_end_or_count_pin <= `DMAHS_PIN_IDLE;
  end

  // Each pin is driven only while its channel has it set as an output
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_channel_end_or_count_pin_oe_n <= `DMAHS_PIN_OE_OFF;
    else
      o_channel_end_or_count_pin_oe_n <= ~pin_out_en; // R6
  end

  // Buffer end pulse, by count or by end input
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_buffer_done <= 4'h0;
    else if (state_q == DMAHS_DONE && (buf_last || end_q))
      o_buffer_done <= onehot(chan_q); // R10
    else
      o_buffer_done <= 4'h0;
  end

  // Termination pulse; a chained channel goes on with its next buffer instead
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_chan_terminated <= 4'h0;
    else if (state_q == DMAHS_DONE && end_q && !i_cfg[chan_q].src_dst_chain)
      o_chan_terminated <= onehot(chan_q); // R7 R8
    else
      o_chan_terminated <= 4'h0;
  end

  // Status of the channel in service
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_status <= '0;
    else
    begin
      o_status.busy <= (state_d != DMAHS_IDLE);
      o_status.chan <= chan_q;
      o_status.remaining <= cnt_q[chan_q];
    end
  end

endmodule

// File: dmahs_properties.sv
/* Checker on the ports of dmahs_top, bound into every instance.
   Assumes active-low pins and cfg held steady while a channel runs. */
`timescale 1ns/100ps
module dmahs_properties
  import dmahs_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic [3:0] i_channel_transfer_request_n, // Requests
  input wire logic [3:0] o_channel_transfer_ack_n, // Acks
  input wire logic [3:0] o_channel_end_or_count_pin, // Pin out
  input wire logic [3:0] o_channel_end_or_count_pin_oe_n, // Pin drive
  input wire dmahs_chan_cfg_t [3:0] i_cfg, // Setup
  input wire logic [3:0] o_buffer_done // Buffer end
);
  wire [3:0] ack = o_channel_transfer_ack_n;
  wire [3:0] tc = o_channel_end_or_count_pin;
  wire [3:0] oe = o_channel_end_or_count_pin_oe_n;
  logic [3:0] pio;
  always_comb
    for (int n = 0; n < 4; n++)
      pio[n] = i_cfg[n].pin_is_output;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  reset_idle_a: assert property ($rose(i_nrst) |-> ack == 4'hf && oe == 4'hf)
    else $error("not idle after reset");
  ack_onehot_a: assert property ($onehot0(~ack))
    else $error("two acks");
  ack_cause_a: assert property ((~ack & $past(ack)) != 4'h0 |->
    (~ack & $past(ack) & $past(i_channel_transfer_request_n, 2)) == 4'h0)
    else $error("ack without request");
  ack_length_a: assert property ((ack != 4'hf) [*4] |=> ack == 4'hf)
    else $error("ack too long");
  oe_follow_a: assert property ($past(i_nrst) |-> oe == ~$past(pio))
    else $error("pin drive wrong");
  tc_drive_a: assert property ((~tc & oe) == 4'h0)
    else $error("count-done undriven");
  tc_timing_a: assert property ((~tc & ~oe & ack) == 4'h0)
    else $error("count-done without ack");
  done_pulse_a: assert property (o_buffer_done != 4'h0 |->
    $onehot(o_buffer_done) ##1 o_buffer_done == 4'h0)
    else $error("bad done pulse");
endmodule
bind dmahs_top dmahs_properties u_props (.*);

// File: dmahs_periph.sv
/* Requesting peripherals, one per channel, each with a count of wanted transfers.
   Assumes active-low acks from the device. */
`timescale 1ns/100ps
module dmahs_periph
(
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic [3:0] i_ack_n, // Acks
  input wire logic [3:0] i_add, // One more transfer wanted
  output logic [3:0] o_req_n // Requests
);
  logic [3:0][3:0] pend_q;
  logic [3:0] ack_q;
  always_ff @(posedge i_clk)
  begin
    ack_q <= i_ack_n;
    for (int n = 0; n < 4; n++)
      pend_q[n] <= !i_nrst ? 4'h0 : pend_q[n] + 4'(i_add[n]) - 4'(!i_ack_n[n] && ack_q[n]);
  end
  always_comb
    for (int n = 0; n < 4; n++)
      o_req_n[n] = pend_q[n] == 4'h0;
endmodule

// File: test_dmahs_top.sv
/* Self-checking bench for dmahs_top with the peripheral model.
   Assumes the package, model and checker are compiled first. */
`timescale 1ns/100ps
module test_dmahs_top
  import dmahs_pkg::*;
;
  logic clk = 0, nrst = 0, prio = 0;
  logic [3:0] req_n, ack_n, pout, oe_n, done, term, pin, en = 4'hf, eop = 4'hf, add = 4'h0;
  logic [3:0] ap = 4'hf;
  dmahs_chan_cfg_t [3:0] cfg;
  dmahs_status_t st;
  int error_cnt, n_checks, c, a, k, ackc[4], tcc[4], donec[4], termc[4];
  int gq[$];
  initial forever #50 clk = ~clk;
  assign pin = (~oe_n & pout) | (oe_n & eop);
  dmahs_periph u_per (.i_clk(clk), .i_nrst(nrst), .i_ack_n(ack_n), .i_add(add), .o_req_n(req_n));
  dmahs_top uut (.i_clk(clk), .i_nrst(nrst), .i_channel_transfer_request_n(req_n),
    .o_channel_transfer_ack_n(ack_n), .i_channel_end_or_count_pin(pin),
    .o_channel_end_or_count_pin(pout), .o_channel_end_or_count_pin_oe_n(oe_n),
    .i_prio_mode(prio), .i_cfg(cfg), .i_chan_enable(en), .o_buffer_done(done),
    .o_chan_terminated(term), .o_status(st));
  always @(posedge clk)
  begin
    ap <= ack_n;
    for (int n = 0; n < 4; n++)
    begin
      ackc[n] += int'(!ack_n[n]);
      tcc[n] += int'(!pout[n] && !oe_n[n]);
      donec[n] += int'(done[n]);
      termc[n] += int'(term[n]);
      if (!ack_n[n] && ap[n])
        gq.push_back(n);
    end
  end
  function automatic int acks(input int cnt, input int acc);
    return cnt * (1 + acc);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [3:0] m, input int n, input int want);
    int t;
    @(negedge clk);
    gq.delete();
    ackc = '{default: 0};
    tcc = '{default: 0};
    donec = '{default: 0};
    termc = '{default: 0};
    repeat (n) @(posedge clk) add <= m;
    @(posedge clk) add <= 4'h0;
    for (t = 0; t < 500 && (gq.size() < want || st.busy !== 1'b0 || req_n !== 4'hf); t++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    if (t == 500)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  initial
  begin
    void'($urandom(73));
    cfg = {4{dmahs_chan_cfg_t'{1'b1, 1'b0, 16'h0001, 2'h0, 1'b1}}};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk({ack_n, oe_n, done, term}, 16'hf000);
    run(4'hf, 1, 4);
    for (int i = 0; i < 4; i++)
    begin
      chk(gq[i], i);
      chk(tcc[i], acks(1, 0));
      chk(donec[i], 1);
    end
    prio <= 1'b1;
    for (int i = 0; i < 4; i++)
      cfg[i].byte_count <= 16'h0002;
    run(4'hf, 2, 8);
    for (int i = 1; i < 8; i++)
      chk(gq[i], (gq[i - 1] + 1) % 4);
    chk(tcc[3], 1);
    repeat (6)
    begin
      prio <= 1'($urandom);
      c = $urandom % 4;
      a = $urandom % 4;
      k = 1 + $urandom % 4;
      cfg[c] <= '{1'b1, 1'b0, 16'(k), 2'(a), 1'($urandom)};
      run(4'h1 << c, k, k);
      chk(ackc[c], acks(k, a));
      chk(tcc[c], acks(1, a));
      chk(donec[c], 1);
      chk(st.chan, c);
      chk(st.remaining, 0);
    end
    cfg[1] <= '{1'b0, 1'b0, 16'h0008, 2'h0, 1'b1};
    cfg[2] <= '{1'b0, 1'b1, 16'h0008, 2'h1, 1'b0};
    eop <= 4'h9;
    run(4'h6, 1, 2);
    chk(termc[1], 1);
    chk(termc[2], 0);
    chk(donec[1], 1);
    chk(donec[2], 1);
    chk(oe_n[2:1], 2'h3);
    chk(tcc[1] + tcc[2], 0);
    eop <= 4'hf;
    run(4'h4, 1, 1);
    chk(donec[2], 0);
    chk(st.remaining, 7);
    en <= 4'hb;
    run(4'h4, 1, 0);
    repeat (30) @(posedge clk);
    chk(ackc[2], 0);
    en <= 4'hf;
    run(4'h0, 1, 1);
    chk(gq[0], 2);
    chk(st.remaining, 6);
    end_of_test();
  end
endmodule
